//--- core/alu_timing_cfg.svh
`ifndef ALU_TIMING_CFG_SVH
`define ALU_TIMING_CFG_SVH
// ****************
// clock and timing
// ****************
`define CLK_PERIOD_NS 4
`define INSN_CYCLE_NS 4
`define CLK_PER_CYCLE (`INSN_CYCLE_NS / `CLK_PERIOD_NS)
`define CYC_W 3
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_THREE 3'h3
`define CYC_FOUR 3'h4
`define CYC_FIVE 3'h5
// ****************
// fixed opcodes
// ****************
`define OPC_MUL 8'hA4
`define OPC_DIV 8'h84
`define OPC_DA 8'hD4
`define OPC_CLR 8'hE4
`define OPC_CPL 8'hF4
`define OPC_SWAP 8'hC4
`define OPC_INC_A 8'h04
`define OPC_INC_DIR 8'h05
`define OPC_ANL_DIR_IMM 8'h53
`define OPC_ADD_RN 5'h05
`define OPC_SUBTRACT_WITH_BORROW_OP_RN 5'h13
`define OPC_ADD_DIR 8'h25
`define OPC_SUBTRACT_WITH_BORROW_OP_DIR 8'h95
`define OPC_DEC_DIR 8'h15
`define OPC_ORL_DIR_A 8'h42
`define OPC_XRL_DIR 8'h65
`define OPC_MOV_A_IMM 8'h74
`define OPC_MOV_RN_DIR 5'h15
`define OPC_MOV_DIR_RN 5'h11
// ****************
// status word layout and resets
// ****************
`define PSW_CY 7
`define PSW_AC 6
`define PSW_OV 2
`define PSW_P 0
`define ACC_RST 8'h00
`define BYTE_ZERO 8'h00
`define BCD_MAX 4'h9
`define BCD_LO_FIX 9'h006
`define BCD_HI_FIX 9'h060
`endif

//--- core/alu_timing_pkg.sv
package alu_timing_pkg;
  `include "alu_timing_cfg.svh"
  typedef enum logic [4:0] {
    OP_NONE, OP_ADD, OP_ADD_WITH_CARRY_OP, OP_SUBTRACT_WITH_BORROW_OP, OP_INC, OP_DEC, OP_MUL, OP_DIV,
    OP_DA, OP_AND, OP_OR, OP_XOR, OP_CLR, OP_CPL, OP_RL, OP_RLC, OP_RR,
    OP_RRC, OP_SWAP, OP_MOV
  } op_class_t;
  typedef enum logic [1:0] {Y_OPND, Y_IMM, Y_ACC} y_sel_t;
  typedef enum logic {X_ACC, X_OPND} x_sel_t;
  typedef enum logic [1:0] {DST_NONE, DST_ACC, DST_EXT, DST_AB} dst_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} state_t;
  typedef struct packed {
    state_t state;
    logic [`CYC_W-1:0] count;
    op_class_t cls;
    y_sel_t ySel;
    x_sel_t xSel;
    dst_t dst;
    logic [7:0] operand;
    logic [7:0] imm;
    logic [7:0] acc;
    logic [7:0] b;
    logic cy;
    logic ac;
    logic ov;
    logic par;
    logic [7:0] result;
    logic resWr;
    logic done;
  } alu_state_t;
endpackage

//--- core/alu_decode_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "alu_timing_cfg.svh"
interface alu_decode_if;
  import alu_timing_pkg::*;
  logic [7:0] opcode;
  op_class_t cls;
  y_sel_t ySel;
  x_sel_t xSel;
  dst_t dst;
  logic [`CYC_W-1:0] cycles;
  modport dec (input opcode, output cls, ySel, xSel, dst, cycles);
  modport core (output opcode, input cls, ySel, xSel, dst, cycles);
endinterface
`default_nettype wire

//--- core/alu_op_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "alu_timing_cfg.svh"
module alu_op_decode
  import alu_timing_pkg::*;
(
  alu_decode_if.dec dec
);
  logic [3:0] hi;
  logic [3:0] lo;
  logic isRn;
  assign hi = dec.opcode[7:4];
  assign lo = dec.opcode[3:0];
  assign isRn = dec.opcode[3];

  always_comb begin
    dec.cls = OP_NONE;
    dec.ySel = Y_OPND;
    dec.xSel = X_ACC;
    dec.dst = DST_NONE;
    dec.cycles = `CYC_ONE;
    case (hi)
      4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6: begin
        case (hi)
          4'h2: dec.cls = OP_ADD;
          4'h3: dec.cls = OP_ADD_WITH_CARRY_OP;
          4'h9: dec.cls = OP_SUBTRACT_WITH_BORROW_OP;
          4'h4: dec.cls = OP_OR;
          4'h5: dec.cls = OP_AND;
          default: dec.cls = OP_XOR;
        endcase
        if (isRn) begin
          dec.dst = DST_ACC;
        end else if (lo == 4'h4 || lo == 4'h5 || lo == 4'h6 || lo == 4'h7) begin
          dec.dst = DST_ACC;
          dec.cycles = `CYC_TWO;
          dec.ySel = (lo == 4'h4) ? Y_IMM : Y_OPND;
        end else if ((lo == 4'h2 || lo == 4'h3) && (hi == 4'h4 || hi == 4'h5
            || hi == 4'h6)) begin
          dec.dst = DST_EXT;
          dec.xSel = X_OPND;
          dec.ySel = (lo == 4'h2) ? Y_ACC : Y_IMM;
          dec.cycles = (lo == 4'h2) ? `CYC_THREE : `CYC_FOUR;
        end else if (lo == 4'h3 && (hi == 4'h2 || hi == 4'h3)) begin
          dec.cls = (hi == 4'h2) ? OP_RL : OP_RLC;
          dec.dst = DST_ACC;
        end else begin
          dec.cls = OP_NONE;
        end
      end
      4'h0, 4'h1: begin
        dec.cls = (hi == 4'h0) ? OP_INC : OP_DEC;
        if (lo == 4'h4) begin
          dec.dst = DST_ACC;
        end else if (isRn) begin
          dec.dst = DST_EXT;
          dec.xSel = X_OPND;
          dec.cycles = `CYC_TWO;
        end else if (lo == 4'h5 || lo == 4'h6 || lo == 4'h7) begin
          dec.dst = DST_EXT;
          dec.xSel = X_OPND;
          dec.cycles = `CYC_THREE;
        end else if (lo == 4'h3) begin
          dec.cls = (hi == 4'h0) ? OP_RR : OP_RRC;
          dec.dst = DST_ACC;
        end else begin
          dec.cls = OP_NONE;
        end
      end
      4'hA, 4'h8: begin
        if (lo == 4'h4) begin
          dec.cls = (hi == 4'hA) ? OP_MUL : OP_DIV;
          dec.dst = DST_AB;
          dec.cycles = `CYC_FIVE;
        end else if (isRn || lo == 4'h5 || lo == 4'h6 || lo == 4'h7) begin
          dec.cls = OP_MOV;
          dec.dst = DST_EXT;
          dec.cycles = (hi == 4'h8 && isRn) ? `CYC_THREE : `CYC_FOUR;
          if (hi == 4'hA && !isRn) begin
            dec.cls = OP_NONE;
            dec.dst = DST_NONE;
            dec.cycles = `CYC_ONE;
          end
        end
      end
      4'hC: if (lo == 4'h4) begin
        dec.cls = OP_SWAP;
        dec.dst = DST_ACC;
      end
      4'hD: if (lo == 4'h4) begin
        dec.cls = OP_DA;
        dec.dst = DST_ACC;
      end
      4'hE: begin
        if (lo == 4'h4) begin
          dec.cls = OP_CLR;
          dec.dst = DST_ACC;
        end else if (isRn || lo == 4'h5 || lo == 4'h6 || lo == 4'h7) begin
          dec.cls = OP_MOV;
          dec.dst = DST_ACC;
          dec.cycles = isRn ? `CYC_ONE : `CYC_TWO;
        end
      end
      4'hF: begin
        if (lo == 4'h4) begin
          dec.cls = OP_CPL;
          dec.dst = DST_ACC;
        end else if (isRn || lo == 4'h5) begin
          dec.cls = OP_MOV;
          dec.dst = DST_EXT;
          dec.ySel = Y_ACC;
          dec.cycles = isRn ? `CYC_TWO : `CYC_THREE;
        end
      end
      4'h7: begin
        if (lo == 4'h4 || isRn) begin
          dec.cls = OP_MOV;
          dec.ySel = Y_IMM;
          dec.dst = isRn ? DST_EXT : DST_ACC;
          dec.cycles = `CYC_TWO;
        end
      end
      default: dec.cls = OP_NONE;
    endcase
  end
endmodule
`default_nettype wire

//--- core/mcu_alu_core.sv
// Behaviour
// - add with/without carry, subtract with borrow
// - multiply and divide A by B, five cycles
// - bitwise AND, OR, XOR and NOT
// - all arithmetic on unsigned bytes
// - increment or decrement any byte operand
// - accumulator rotates, swap, clear, complement, adjust
// - operands from A, B or outside
// - status word holds carry, overflow, parity
// - add register forms take one cycle
// - direct, indirect, immediate adds take two cycles
// - subtract register one cycle, others two
// - increment A 1, register 2, memory 3
// - decrement A 1, register 2, memory 3
// - AND timings one, two, three, four cycles
// - OR timings one, two, three, four cycles
// - XOR timings one, two, three, four cycles
// - clear, complement, swap, rotates one cycle
// - load accumulator one or two cycles
// - register writes two or four cycles
// - direct writes three or four cycles
// - legacy encodings and results kept
// - one instruction cycle per clock
`timescale 1ns/1ps
`default_nettype none
`include "alu_timing_cfg.svh"
module mcu_alu_core
  import alu_timing_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // instruction request from decoder
  input wire logic insnStart,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operandIn,
  input wire logic [7:0] immediateIn,
  // architectural state
  output var logic [7:0] accumulator_reg,
  output var logic [7:0] operandBReg,
  output var logic [7:0] processor_status_word,
  // result towards internal buses
  output var logic [7:0] resultOut,
  output var logic resultWrite,
  output var logic insnDone,
  output var logic busy
);
  // ****************
  // state and decode
  // ****************
  alu_state_t s_reg;
  alu_state_t s_next;
  alu_decode_if dec ();
  alu_op_decode decoder (
    .dec(dec)
  );
  assign dec.opcode = opcode;

  logic accept;
  logic finish;
  op_class_t curCls;
  y_sel_t curY;
  x_sel_t curX;
  dst_t curDst;
  logic [7:0] curOpnd;
  logic [7:0] curImm;
  assign accept = insnStart && (s_reg.state == ST_IDLE);
  assign curCls = accept ? dec.cls : s_reg.cls;
  assign curY = accept ? dec.ySel : s_reg.ySel;
  assign curX = accept ? dec.xSel : s_reg.xSel;
  assign curDst = accept ? dec.dst : s_reg.dst;
  assign curOpnd = accept ? operandIn : s_reg.operand;
  assign curImm = accept ? immediateIn : s_reg.imm;
  assign finish = accept ? (dec.cycles == `CYC_ONE)
    : (s_reg.state == ST_EXEC && s_reg.count == `CYC_ONE);

  // ****************
  // datapath
  // ****************
  logic [7:0] x;
  logic [7:0] y;
  logic cin;
  logic [8:0] sum9;
  logic [8:0] diff9;
  logic [4:0] nibSum;
  logic [4:0] nibDiff;
  logic [15:0] prod;
  logic [8:0] daLo;
  logic [8:0] daHi;
  logic [7:0] val;

  always_comb begin
    // operands from accumulator, B register or outside
    x = (curX == X_OPND) ? curOpnd : s_reg.acc;
    case (curY)
      Y_IMM: y = curImm;
      Y_ACC: y = s_reg.acc;
      default: y = curOpnd;
    endcase
    cin = (curCls == OP_ADD_WITH_CARRY_OP) ? s_reg.cy : 1'b0;
    // zero extension only, no sign handling
    sum9 = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    diff9 = {1'b0, x} - {1'b0, y} - {8'h00, s_reg.cy};
    nibSum = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
    nibDiff = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, s_reg.cy};
    prod = {8'h00, x} * {8'h00, s_reg.b};
    daLo = {1'b0, s_reg.acc};
    if (s_reg.acc[3:0] > `BCD_MAX || s_reg.ac) begin
      daLo = daLo + `BCD_LO_FIX;
    end
    daHi = daLo;
    if (daLo[8] || daLo[7:4] > `BCD_MAX || s_reg.cy) begin
      daHi = daLo + `BCD_HI_FIX;
    end
  end

  // ****************
  // next state
  // ****************
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.resWr = 1'b0;
    val = x;
    if (accept) begin
      s_next.state = ST_EXEC;
      s_next.count = dec.cycles - `CYC_ONE;
      s_next.cls = dec.cls;
      s_next.ySel = dec.ySel;
      s_next.xSel = dec.xSel;
      s_next.dst = dec.dst;
      s_next.operand = operandIn;
      s_next.imm = immediateIn;
    end else if (s_reg.state == ST_EXEC) begin
      s_next.count = s_reg.count - `CYC_ONE;
    end
    if (finish) begin
      s_next.state = ST_IDLE;
      s_next.done = 1'b1;
      case (curCls)
        OP_ADD, OP_ADD_WITH_CARRY_OP: begin
          val = sum9[7:0];
          s_next.cy = sum9[8];
          s_next.ac = nibSum[4];
          s_next.ov = (x[7] == y[7]) && (sum9[7] != x[7]);
        end
        OP_SUBTRACT_WITH_BORROW_OP: begin
          val = diff9[7:0];
          s_next.cy = diff9[8];
          s_next.ac = nibDiff[4];
          s_next.ov = (x[7] != y[7]) && (diff9[7] != x[7]);
        end
        OP_INC: val = x + 8'h01;
        OP_DEC: val = x - 8'h01;
        OP_AND: val = x & y;
        OP_OR: val = x | y;
        OP_XOR: val = x ^ y;
        OP_CPL: val = ~s_reg.acc;
        OP_CLR: val = `BYTE_ZERO;
        OP_SWAP: val = {s_reg.acc[3:0], s_reg.acc[7:4]};
        OP_RL: val = {s_reg.acc[6:0], s_reg.acc[7]};
        OP_RR: val = {s_reg.acc[0], s_reg.acc[7:1]};
        OP_RLC: begin
          val = {s_reg.acc[6:0], s_reg.cy};
          s_next.cy = s_reg.acc[7];
        end
        OP_RRC: begin
          val = {s_reg.cy, s_reg.acc[7:1]};
          s_next.cy = s_reg.acc[0];
        end
        OP_DA: begin
          val = daHi[7:0];
          s_next.cy = s_reg.cy | daLo[8] | daHi[8];
        end
        OP_MOV: val = y;
        OP_MUL: begin
          s_next.cy = 1'b0;
          s_next.ov = (prod[15:8] != `BYTE_ZERO);
          s_next.acc = prod[7:0];
          s_next.b = prod[15:8];
        end
        OP_DIV: begin
          s_next.cy = 1'b0;
          s_next.ov = (s_reg.b == `BYTE_ZERO);
          if (s_reg.b != `BYTE_ZERO) begin
            s_next.acc = x / s_reg.b;
            s_next.b = x % s_reg.b;
          end
        end
        default: val = x;
      endcase
      // result to accumulator or out onto the buses
      if (curDst == DST_ACC) begin
        s_next.acc = val;
      end else if (curDst == DST_EXT) begin
        s_next.result = val;
        s_next.resWr = 1'b1;
      end
    end
    s_next.par = ^s_next.acc;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************
  // outputs
  // ****************
  always_comb begin
    processor_status_word = `BYTE_ZERO;
    processor_status_word[`PSW_CY] = s_reg.cy;
    processor_status_word[`PSW_AC] = s_reg.ac;
    processor_status_word[`PSW_OV] = s_reg.ov;
    processor_status_word[`PSW_P] = s_reg.par;
  end
  assign accumulator_reg = s_reg.acc;
  assign operandBReg = s_reg.b;
  assign resultOut = s_reg.result;
  assign resultWrite = s_reg.resWr;
  assign insnDone = s_reg.done;
  assign busy = (s_reg.state == ST_EXEC);

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence seqDoneAfterOne;
    insnDone;
  endsequence
  sequence seqDoneAfterTwo;
    !insnDone ##1 insnDone;
  endsequence
  sequence seqDoneAfterThree;
    !insnDone [*2] ##1 insnDone;
  endsequence
  sequence seqWriteAfterThree;
    (!insnDone && !resultWrite) [*2] ##1 (insnDone && resultWrite);
  endsequence
  sequence seqDoneAfterFour;
    !insnDone [*3] ##1 insnDone;
  endsequence
  sequence seqDoneAfterFive;
    !insnDone [*4] ##1 insnDone;
  endsequence

  a_muldiv_five_cycles: assert property (
    accept && (opcode == `OPC_MUL || opcode == `OPC_DIV) |=> seqDoneAfterFive)
    else $error("multiply or divide not done in five cycles");
  a_add_reg_one_cycle: assert property (
    accept && opcode[7:3] == `OPC_ADD_RN |=> seqDoneAfterOne)
    else $error("add register not done in one cycle");
  a_inc_direct_three: assert property (
    accept && opcode == `OPC_INC_DIR |=> seqWriteAfterThree)
    else $error("increment direct not done in three cycles");
  a_and_imm_four: assert property (
    accept && opcode == `OPC_ANL_DIR_IMM |=> seqDoneAfterFour)
    else $error("and direct immediate not done in four cycles");
  a_add_reg_value: assert property (
    accept && opcode[7:3] == `OPC_ADD_RN
    |=> accumulator_reg == 8'($past(accumulator_reg) + $past(operandIn)))
    else $error("add register result wrong");
  a_subtract_with_borrow_op_borrow_flag: assert property (
    accept && opcode[7:3] == `OPC_SUBTRACT_WITH_BORROW_OP_RN
    |=> processor_status_word[`PSW_CY] == ({1'b0, $past(accumulator_reg)}
      < ({1'b0, $past(operandIn)} + {8'h00, $past(processor_status_word[`PSW_CY])})))
    else $error("subtract borrow flag wrong");
  a_parity_tracks_acc: assert property (
    processor_status_word[`PSW_P] == ^accumulator_reg)
    else $error("parity flag does not match accumulator");
  a_cpl_inverts: assert property (
    accept && opcode == `OPC_CPL |=> accumulator_reg == ~$past(accumulator_reg))
    else $error("complement result wrong");
  a_swap_nibbles: assert property (
    accept && opcode == `OPC_SWAP
    |=> accumulator_reg == {$past(accumulator_reg[3:0]), $past(accumulator_reg[7:4])})
    else $error("swap result wrong");
  a_inc_acc_value: assert property (
    accept && opcode == `OPC_INC_A |=> insnDone
    && accumulator_reg == 8'($past(accumulator_reg) + 8'h01))
    else $error("increment accumulator wrong");
  a_mul_product: assert property (
    accept && opcode == `OPC_MUL |=> ##4 {operandBReg, accumulator_reg}
      == 16'($past(accumulator_reg, 5) * $past(operandBReg, 5)))
    else $error("multiply product wrong");
  a_busy_no_done: assert property (
    insnDone |-> !busy)
    else $error("done while still busy");
  a_add_direct_two: assert property (
    accept && opcode == `OPC_ADD_DIR |=> seqDoneAfterTwo)
    else $error("add direct not done in two cycles");
  a_subtract_with_borrow_op_direct_two: assert property (
    accept && opcode == `OPC_SUBTRACT_WITH_BORROW_OP_DIR |=> seqDoneAfterTwo)
    else $error("subtract direct not done in two cycles");
  a_dec_direct_three: assert property (
    accept && opcode == `OPC_DEC_DIR |=> seqWriteAfterThree)
    else $error("decrement direct not done in three cycles");
  a_orl_dir_three: assert property (
    accept && opcode == `OPC_ORL_DIR_A |=> seqWriteAfterThree)
    else $error("or direct accumulator not done in three cycles");
  a_xrl_direct_two: assert property (
    accept && opcode == `OPC_XRL_DIR |=> seqDoneAfterTwo)
    else $error("xor direct not done in two cycles");
  a_load_imm_two: assert property (
    accept && opcode == `OPC_MOV_A_IMM
    |=> seqDoneAfterTwo ##0 accumulator_reg == $past(immediateIn, 2))
    else $error("load immediate wrong or not in two cycles");
  a_mov_rn_four: assert property (
    accept && opcode[7:3] == `OPC_MOV_RN_DIR |=> seqDoneAfterFour)
    else $error("register load from direct not done in four cycles");
  a_mov_dir_three: assert property (
    accept && opcode[7:3] == `OPC_MOV_DIR_RN |=> seqWriteAfterThree)
    else $error("direct write from register not done in three cycles");
  a_div_zero_flag: assert property (
    accept && opcode == `OPC_DIV && operandBReg == `BYTE_ZERO
    |=> ##4 (insnDone && processor_status_word[`PSW_OV]))
    else $error("divide by zero overflow flag wrong");
endmodule
`default_nettype wire

//--- verification/alu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module alu_bus_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // result bus from the unit
  input wire logic [7:0] resultOut,
  input wire logic resultWrite,
  // memory side view
  output var logic [7:0] memByte,
  output var logic [7:0] wrCount
);
  // ****************
  // data memory write port
  // ****************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      memByte <= 8'h00;
      wrCount <= 8'h00;
    end else if (resultWrite) begin
      memByte <= resultOut;
      wrCount <= wrCount + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- verification/test_mcu_alu_instruction_timing.sv
`timescale 1ns/1ps
`default_nettype none
module test_mcu_alu_instruction_timing;
  import alu_timing_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic insnStart = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] operandIn = 8'h00;
  logic [7:0] immediateIn = 8'h00;
  logic [7:0] accumulator_reg;
  logic [7:0] operandBReg;
  logic [7:0] processor_status_word;
  logic [7:0] resultOut;
  logic [7:0] memByte;
  logic [7:0] wrCount;
  logic [7:0] wrExp = 8'h00;
  logic resultWrite;
  logic insnDone;
  logic busy;
  int fail_count = 0;
  int n_compared = 0;
  always #2 clk_sys = ~clk_sys;
  mcu_alu_core i_dut (
    .clk_sys(clk_sys), .rst(rst), .insnStart(insnStart), .opcode(opcode),
    .operandIn(operandIn), .immediateIn(immediateIn), .accumulator_reg(accumulator_reg),
    .operandBReg(operandBReg), .processor_status_word(processor_status_word),
    .resultOut(resultOut), .resultWrite(resultWrite), .insnDone(insnDone), .busy(busy)
  );
  alu_bus_model i_mem (
    .clk_sys(clk_sys), .rst(rst), .resultOut(resultOut), .resultWrite(resultWrite),
    .memByte(memByte), .wrCount(wrCount)
  );
  // ****************
  // shared tasks
  // ****************
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic run(input logic [7:0] op, input logic [7:0] opnd, input logic [7:0] imm,
                     input logic [7:0] cyc);
    logic [7:0] n;
    logic seen;
    n = 8'h00;
    seen = 1'b0;
    @(posedge clk_sys);
    insnStart <= 1'b1;
    opcode <= op;
    operandIn <= opnd;
    immediateIn <= imm;
    @(posedge clk_sys);
    insnStart <= 1'b0;
    operandIn <= ~opnd;
    immediateIn <= ~imm;
    while (!seen && n < 8'h0A) begin
      #1;
      n = n + 8'h01;
      seen = (insnDone === 1'b1);
      if (!seen) begin
        @(posedge clk_sys);
      end
    end
    if (!seen) begin
      fail_count++;
      $display("[FAIL] done expected 1 seen 0");
      results();
    end
    check("cycles", n, cyc);
  endtask
  task automatic chkA(input logic [7:0] e);
    check("acc", accumulator_reg, e);
    check("parity", {7'h00, processor_status_word[0]}, {7'h00, ^e});
  endtask
  task automatic memchk(input logic [7:0] e);
    wrExp = wrExp + 8'h01;
    check("resultOut", resultOut, e);
    @(posedge clk_sys);
    #1;
    check("memByte", memByte, e);
    check("writes", wrCount, wrExp);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    chkA(8'h00);
    check("b", operandBReg, 8'h00);
    check("psw", processor_status_word, 8'h00);
    check("busy", {7'h00, busy}, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_arith();
    run(8'h74, 8'h00, 8'hC8, 8'h02);
    chkA(8'hC8);
    run(8'h28, 8'h50, 8'h00, 8'h01);
    chkA(8'h18);
    check("psw", processor_status_word, 8'h80);
    run(8'h38, 8'h01, 8'h00, 8'h01);
    chkA(8'h1A);
    check("psw", processor_status_word, 8'h01);
    run(8'h98, 8'h20, 8'h00, 8'h01);
    chkA(8'hFA);
    check("psw", processor_status_word, 8'h80);
    run(8'h25, 8'h06, 8'h00, 8'h02);
    chkA(8'h00);
    check("psw", processor_status_word, 8'hC0);
    run(8'h24, 8'h00, 8'h01, 8'h02);
    chkA(8'h01);
    run(8'h95, 8'h01, 8'h00, 8'h02);
    chkA(8'h00);
    check("psw", processor_status_word, 8'h00);
    $display("test arith done");
  endtask
  task automatic t_muldiv();
    run(8'h74, 8'h00, 8'h0C, 8'h02);
    run(8'h84, 8'h00, 8'h00, 8'h05);
    chkA(8'h0C);
    check("b", operandBReg, 8'h00);
    check("psw", processor_status_word, 8'h04);
    run(8'hA4, 8'h00, 8'h00, 8'h05);
    chkA(8'h00);
    check("psw", processor_status_word, 8'h00);
    $display("test muldiv done");
  endtask
  task automatic t_incdec();
    run(8'h05, 8'hFF, 8'h00, 8'h03);
    memchk(8'h00);
    run(8'h08, 8'h7F, 8'h00, 8'h02);
    memchk(8'h80);
    run(8'h18, 8'h00, 8'h00, 8'h02);
    memchk(8'hFF);
    run(8'h15, 8'h80, 8'h00, 8'h03);
    memchk(8'h7F);
    chkA(8'h00);
    run(8'h14, 8'h00, 8'h00, 8'h01);
    chkA(8'hFF);
    run(8'h04, 8'h00, 8'h00, 8'h01);
    chkA(8'h00);
    $display("test incdec done");
  endtask
  task automatic t_logic();
    logic [7:0] ops [15] = '{8'h58, 8'h55, 8'h54, 8'h52, 8'h53, 8'h48, 8'h45, 8'h44,
                             8'h42, 8'h43, 8'h68, 8'h65, 8'h64, 8'h62, 8'h63};
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] r;
    logic [7:0] c;
    for (int i = 0; i < 15; i++) begin
      run(8'h74, 8'h00, 8'hA5, 8'h02);
      case (ops[i][3:0])
        4'h2: begin x = 8'h3C; y = 8'hA5; c = 8'h03; end
        4'h3: begin x = 8'h3C; y = 8'h0F; c = 8'h04; end
        4'h4: begin x = 8'hA5; y = 8'h0F; c = 8'h02; end
        4'h5: begin x = 8'hA5; y = 8'h3C; c = 8'h02; end
        default: begin x = 8'hA5; y = 8'h3C; c = 8'h01; end
      endcase
      case (ops[i][7:4])
        4'h5: r = x & y;
        4'h4: r = x | y;
        default: r = x ^ y;
      endcase
      run(ops[i], 8'h3C, 8'h0F, c);
      if (ops[i][3:0] < 4'h4) begin
        memchk(r);
        chkA(8'hA5);
      end else begin
        chkA(r);
      end
    end
    $display("test logic done");
  endtask
  task automatic t_accops();
    logic [7:0] ops [5] = '{8'h23, 8'h03, 8'hC4, 8'hF4, 8'hE4};
    logic [7:0] res [5] = '{8'h2D, 8'h96, 8'h69, 8'h96, 8'h00};
    run(8'h74, 8'h00, 8'h96, 8'h02);
    for (int i = 0; i < 5; i++) begin
      run(ops[i], 8'h00, 8'h00, 8'h01);
      chkA(res[i]);
    end
    run(8'h74, 8'h00, 8'h80, 8'h02);
    run(8'h24, 8'h00, 8'h80, 8'h02);
    check("psw", processor_status_word, 8'h84);
    run(8'h33, 8'h00, 8'h00, 8'h01);
    chkA(8'h01);
    check("carry", {7'h00, processor_status_word[7]}, 8'h00);
    run(8'h13, 8'h00, 8'h00, 8'h01);
    chkA(8'h00);
    check("carry", {7'h00, processor_status_word[7]}, 8'h01);
    run(8'hD4, 8'h00, 8'h00, 8'h01);
    chkA(8'h60);
    check("carry", {7'h00, processor_status_word[7]}, 8'h01);
    $display("test accops done");
  endtask
  task automatic t_moves();
    logic [7:0] ops [6] = '{8'hF5, 8'h88, 8'h85, 8'hA8, 8'hF8, 8'h78};
    logic [7:0] cyc [6] = '{8'h03, 8'h03, 8'h04, 8'h04, 8'h02, 8'h02};
    logic [7:0] res [6] = '{8'h60, 8'h33, 8'h33, 8'h33, 8'h60, 8'h77};
    for (int i = 0; i < 6; i++) begin
      run(ops[i], 8'h33, 8'h77, cyc[i]);
      memchk(res[i]);
    end
    run(8'hE8, 8'h12, 8'h00, 8'h01);
    chkA(8'h12);
    run(8'hE5, 8'h34, 8'h00, 8'h02);
    chkA(8'h34);
    run(8'h00, 8'hFF, 8'hFF, 8'h01);
    chkA(8'h34);
    $display("test moves done");
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_arith();
    t_muldiv();
    t_incdec();
    t_logic();
    t_accops();
    t_moves();
    results();
  end
endmodule
`default_nettype wire
